/* core/fan_loop_pkg.sv */
// Shared constants, field layouts and types of the fan loop tuning and spin-up block
package fan_loop_pkg;

  // Register offsets, one set per fan
  localparam logic [7:0] OPT_FAN1_ADDR = 8'h33;
  localparam logic [7:0] GAIN_FAN1_ADDR = 8'h35;
  localparam logic [7:0] SPIN_FAN1_ADDR = 8'h36;
  localparam logic [7:0] OPT_FAN2_ADDR = 8'h43;
  localparam logic [7:0] GAIN_FAN2_ADDR = 8'h45;
  localparam logic [7:0] SPIN_FAN2_ADDR = 8'h46;

  // Reset values and writable-bit masks
  localparam logic [7:0] OPT_RESET = 8'h28;
  localparam logic [7:0] GAIN_RESET = 8'h2a;
  localparam logic [7:0] SPIN_RESET = 8'h19;
  localparam logic [7:0] OPT_MASK = 8'h7e;
  localparam logic [7:0] GAIN_MASK = 8'h3f;
  localparam logic [7:0] SPIN_MASK = 8'hff;

  // Timing: system clock rate and the base units of the selectable periods
  localparam int CLK_KHZ = 10000;
  localparam int UPDATE_UNIT_MS = 100;
  localparam int UPDATE_UNIT_CYCLES = UPDATE_UNIT_MS * CLK_KHZ;
  localparam int SPIN_UNIT_MS = 250;
  localparam int SPIN_UNIT_CYCLES = SPIN_UNIT_MS * CLK_KHZ;

  // Deadband widths in tach counts for the 50, 100 and 200 RPM windows
  localparam logic [15:0] WIN_50RPM_COUNT = 16'h0008;
  localparam logic [15:0] WIN_100RPM_COUNT = 16'h0010;
  localparam logic [15:0] WIN_200RPM_COUNT = 16'h0020;

  // Drive-fail window base (16 update periods), full drive code, loop scaling, filter length
  localparam logic [6:0] FAIL_BASE_PERIODS = 7'h10;
  localparam logic [7:0] DRIVE_FULL = 8'hff;
  localparam int LOOP_SHIFT = 4;
  localparam int FILTER_LEN = 4;

  typedef enum logic [1:0] {
    DER_NONE = 2'b00,
    DER_BASIC = 2'b01,
    DER_STEP = 2'b10,
    DER_BOTH = 2'b11
  } deriv_e;

  typedef enum logic [1:0] {
    ST_DIRECT = 2'b00,
    ST_KICK = 2'b01,
    ST_LEVEL = 2'b10,
    ST_RUN = 2'b11
  } spin_state_e;

  // Loop options register layout
  typedef struct packed {
    logic unused_hi;
    logic direct_ramp_limit_on;
    logic tach_noise_filter_on;
    deriv_e deriv_option_sel;
    logic [1:0] error_window_sel;
    logic unused_lo;
  } loop_opts_s;

  // PID gain register layout
  typedef struct packed {
    logic [1:0] unused_hi;
    logic [1:0] kd_select;
    logic [1:0] ki_select;
    logic [1:0] kp_select;
  } pid_gains_s;

  // Spin-up setup register layout
  typedef struct packed {
    logic [1:0] underdrive_window_sel;
    logic skip_full_kick;
    logic [2:0] spinup_drive_level;
    logic [1:0] spinup_duration_sel;
  } spinup_setup_s;

  // Register write strobe with its address and data
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

endpackage

/* core/update_ticker.sv */
// Update-period tick generator for the loop and ramp logic
`timescale 1ns/10ps
module update_ticker #(
  parameter int UNIT_CYCLES = fan_loop_pkg::UPDATE_UNIT_CYCLES
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Period select and tick
  input wire logic [2:0] update_period_sel,
  output logic tick
);

  logic [31:0] count;
  logic [31:0] period;

  // Multiples of the 100 ms unit: 1,2,3,4,5,8,12,16
  function automatic logic [4:0] period_mult(input logic [2:0] sel);
    case (sel)
      3'h0: period_mult = 5'h01;
      3'h1: period_mult = 5'h02;
      3'h2: period_mult = 5'h03;
      3'h3: period_mult = 5'h04;
      3'h4: period_mult = 5'h05;
      3'h5: period_mult = 5'h08;
      3'h6: period_mult = 5'h0c;
      default: period_mult = 5'h10;
    endcase
  endfunction

  assign period = 32'(UNIT_CYCLES) * {27'h0, period_mult(update_period_sel)};

  // A shortened period restarts the count rather than waiting for a wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (count + 32'h1 >= period);
      count <= (count + 32'h1 >= period) ? 32'h0 : count + 32'h1;
    end
  end

endmodule

/* core/tach_glitch_filter.sv */
// Synchroniser and optional low-pass glitch filter for the rotation pulse pin
`timescale 1ns/10ps
module tach_glitch_filter #(
  parameter int LEN = fan_loop_pkg::FILTER_LEN
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin, filter enable and cleaned output
  input wire logic rotation_pulse_in,
  input wire logic filter_on,
  output logic pulse_clean
);

  logic sync_a;
  logic sync_b;
  logic [7:0] run;
  logic differs;

  assign differs = (sync_b != pulse_clean);

  // Two flops before any logic looks at the pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= rotation_pulse_in;
      sync_b <= sync_a;
    end
  end

  // A new level must hold LEN samples while the filter is on; with it off, short spikes pass straight to the output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run <= 8'h0;
      pulse_clean <= 1'b0;
    end else if (!filter_on) begin
      run <= 8'h0;
      pulse_clean <= sync_b;
    end else if (!differs) begin
      run <= 8'h0;
    end else if (run + 8'h1 >= 8'(LEN)) begin
      run <= 8'h0;
      pulse_clean <= sync_b;
    end else begin
      run <= run + 8'h1;
    end
  end

endmodule

/* core/fan_loop_tuning_and_spinup.sv */
// Per-fan loop options, PID step computation, ramp limiting, drive-fail check and spin-up routine
`timescale 1ns/10ps

module fan_loop_tuning_and_spinup #(
  parameter int FAN_INDEX = 1,
  parameter int UPDATE_UNIT_CYCLES = fan_loop_pkg::UPDATE_UNIT_CYCLES,
  parameter int SPIN_UNIT_CYCLES = fan_loop_pkg::SPIN_UNIT_CYCLES
)(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Register port from the serial interface
  input wire fan_loop_pkg::reg_wr_s REG_WR,
  input wire logic [7:0] REG_RD_ADDR,
  output logic [7:0] REG_RDATA,
  input wire logic SW_LOCK,
  // Settings held by neighbouring blocks
  input wire logic SPEED_LOOP_ON,
  input wire logic [2:0] UPDATE_PERIOD_SEL,
  input wire logic [7:0] FAN_SETTING,
  input wire logic [5:0] MAX_STEP,
  input wire logic [12:0] TACH_READING,
  input wire logic [12:0] TACH_TARGET,
  input wire logic [12:0] VALID_TACH_COUNT,
  input wire logic [12:0] FAIL_BAND,
  // Fan pin and cleaned pulse
  input wire logic ROTATION_PULSE_IN,
  output logic ROTATION_PULSE_CLEAN,
  // Drive and events
  output logic [7:0] DRIVE_SETTING,
  output logic SPIN_ACTIVE,
  output logic SPINUP_FAIL_IRQ,
  output logic DRIVE_FAIL
);

  typedef logic signed [23:0] val_t;

  fan_loop_pkg::loop_opts_s loop_options;
  fan_loop_pkg::pid_gains_s pid_gains;
  fan_loop_pkg::spinup_setup_s spinup_setup;
  fan_loop_pkg::spin_state_e state;
  fan_loop_pkg::spin_state_e next_state;

  logic [7:0] opt_addr;
  logic [7:0] gain_addr;
  logic [7:0] spin_addr;
  logic hit_opt;
  logic hit_gain;
  logic hit_spin;
  logic [7:0] next_rdata;
  logic tick;
  logic [31:0] spin_timer;
  logic [31:0] spin_len;
  logic [31:0] kick_len;
  logic spin_done;
  logic kick_done;
  logic fan_started;
  logic stalled;
  val_t err0;
  val_t err1;
  val_t err2;
  val_t p_term;
  val_t i_term;
  val_t d_term;
  val_t capped_part;
  val_t free_part;
  val_t step_cap;
  logic in_window;
  logic use_basic;
  logic use_step;
  logic [7:0] loop_next;
  logic [7:0] ramp_next;
  logic [7:0] spin_level;
  logic [7:0] next_drive;
  logic [31:0] next_timer;
  logic spin_fail;
  logic restart;
  logic fail_cond;
  logic [6:0] fail_count;
  logic [6:0] fail_limit;

  // Saturate a signed value into the 8-bit drive range
  function automatic logic [7:0] sat8(input val_t v);
    if (v < 0) sat8 = 8'h00;
    else if (v > 24'sd255) sat8 = 8'hff;
    else sat8 = v[7:0];
  endfunction

  // Limit a signed change to plus or minus the step
  function automatic val_t clamp_step(input val_t v, input val_t step);
    if (v > step) clamp_step = step;
    else if (v < -step) clamp_step = -step;
    else clamp_step = v;
  endfunction

  // Spin level percent mapped onto the 0..255 drive scale
  function automatic logic [7:0] level_code(input logic [2:0] sel);
    logic [15:0] pct;
    pct = 16'd30 + 16'd5 * {13'h0, sel};
    level_code = 8'((pct * 16'd255 + 16'd50) / 16'd100);
  endfunction

  // Deadband width for the window select
  function automatic logic [15:0] window_count(input logic [1:0] sel);
    case (sel)
      2'b00: window_count = 16'h0000;
      2'b01: window_count = fan_loop_pkg::WIN_50RPM_COUNT;
      2'b10: window_count = fan_loop_pkg::WIN_100RPM_COUNT;
      default: window_count = fan_loop_pkg::WIN_200RPM_COUNT;
    endcase
  endfunction

  // Address decode for this fan's copy of the registers
  assign opt_addr = (FAN_INDEX == 2) ? fan_loop_pkg::OPT_FAN2_ADDR : fan_loop_pkg::OPT_FAN1_ADDR;
  assign gain_addr = (FAN_INDEX == 2) ? fan_loop_pkg::GAIN_FAN2_ADDR : fan_loop_pkg::GAIN_FAN1_ADDR;
  assign spin_addr = (FAN_INDEX == 2) ? fan_loop_pkg::SPIN_FAN2_ADDR : fan_loop_pkg::SPIN_FAN1_ADDR;
  assign hit_opt = REG_WR.en && (REG_WR.addr == opt_addr);
  assign hit_gain = REG_WR.en && (REG_WR.addr == gain_addr);
  assign hit_spin = REG_WR.en && (REG_WR.addr == spin_addr) && !SW_LOCK;

  // Register stores; masks keep unused bits at zero
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      loop_options <= fan_loop_pkg::loop_opts_s'(fan_loop_pkg::OPT_RESET);
      pid_gains <= fan_loop_pkg::pid_gains_s'(fan_loop_pkg::GAIN_RESET);
      spinup_setup <= fan_loop_pkg::spinup_setup_s'(fan_loop_pkg::SPIN_RESET);
    end else begin
      if (hit_opt) loop_options <= fan_loop_pkg::loop_opts_s'(REG_WR.data & fan_loop_pkg::OPT_MASK);
      if (hit_gain) pid_gains <= fan_loop_pkg::pid_gains_s'(REG_WR.data & fan_loop_pkg::GAIN_MASK);
      if (hit_spin) spinup_setup <= fan_loop_pkg::spinup_setup_s'(REG_WR.data & fan_loop_pkg::SPIN_MASK);
    end
  end

  // Read selection; other addresses answer zero
  assign next_rdata = (REG_RD_ADDR == opt_addr) ? 8'(loop_options) :
                      (REG_RD_ADDR == gain_addr) ? 8'(pid_gains) :
                      (REG_RD_ADDR == spin_addr) ? 8'(spinup_setup) : 8'h00;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) REG_RDATA <= 8'h00;
    else REG_RDATA <= next_rdata;
  end

  // Pin conditioning and update pacing
  tach_glitch_filter u_filter (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .rotation_pulse_in(ROTATION_PULSE_IN),
    .filter_on(loop_options.tach_noise_filter_on),
    .pulse_clean(ROTATION_PULSE_CLEAN)
  );

  update_ticker #(
    .UNIT_CYCLES(UPDATE_UNIT_CYCLES)
  ) u_ticker (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .update_period_sel(UPDATE_PERIOD_SEL),
    .tick(tick)
  );

  // Error terms: a larger tach count means a slower fan, so positive error asks for more drive
  assign err0 = val_t'({11'h0, TACH_READING}) - val_t'({11'h0, TACH_TARGET});
  assign p_term = (err0 - err1) <<< pid_gains.kp_select;
  assign i_term = err0 <<< pid_gains.ki_select;
  assign d_term = (err0 - (err1 <<< 1) + err2) <<< pid_gains.kd_select;
  assign in_window = (err0 < 0 ? -err0 : err0) <= val_t'({8'h0, window_count(loop_options.error_window_sel)});

  // Derivative routing: the basic share is capped with P and I, the step share is not
  assign use_basic = loop_options.deriv_option_sel[0];
  assign use_step = loop_options.deriv_option_sel[1];
  assign step_cap = val_t'({18'h0, MAX_STEP});
  assign capped_part = clamp_step((p_term + i_term + (use_basic ? d_term : 24'sd0)) >>> fan_loop_pkg::LOOP_SHIFT,
                                  step_cap);
  assign free_part = use_step ? (d_term >>> fan_loop_pkg::LOOP_SHIFT) : 24'sd0;
  assign loop_next = sat8(val_t'({16'h0, DRIVE_SETTING}) + capped_part + free_part);

  // Direct-mode ramp toward the written setting
  assign ramp_next = sat8(val_t'({16'h0, DRIVE_SETTING})
                          + clamp_step(val_t'({16'h0, FAN_SETTING}) - val_t'({16'h0, DRIVE_SETTING}), step_cap));

  // Spin-up timing
  assign spin_len = 32'(SPIN_UNIT_CYCLES) << spinup_setup.spinup_duration_sel;
  assign kick_len = spin_len >> 2;
  assign spin_done = (spin_timer + 32'h1 >= spin_len);
  assign kick_done = (spin_timer + 32'h1 >= kick_len);
  assign spin_level = level_code(spinup_setup.spinup_drive_level);
  assign fan_started = (TACH_READING <= VALID_TACH_COUNT);
  assign stalled = !fan_started;
  assign spin_fail = (state == fan_loop_pkg::ST_LEVEL) && spin_done && !fan_started;
  assign restart = spinup_setup.skip_full_kick; // Picks the first spin phase

  // Spin-up and loop sequencing
  always_comb begin
    next_state = state;
    next_drive = DRIVE_SETTING;
    next_timer = spin_timer + 32'h1;
    case (state)
      fan_loop_pkg::ST_DIRECT: begin
        next_timer = 32'h0;
        if (SPEED_LOOP_ON) begin
          next_state = restart ? fan_loop_pkg::ST_LEVEL : fan_loop_pkg::ST_KICK;
        end else if (!loop_options.direct_ramp_limit_on) begin
          next_drive = FAN_SETTING;
        end else if (tick) begin
          next_drive = ramp_next;
        end
      end
      fan_loop_pkg::ST_KICK: begin
        next_drive = fan_loop_pkg::DRIVE_FULL;
        if (kick_done) next_state = fan_loop_pkg::ST_LEVEL;
      end
      fan_loop_pkg::ST_LEVEL: begin
        next_drive = spin_level;
        if (spin_done) begin
          next_timer = 32'h0;
          if (fan_started) next_state = fan_loop_pkg::ST_RUN;
          else next_state = restart ? fan_loop_pkg::ST_LEVEL : fan_loop_pkg::ST_KICK;
        end
      end
      default: begin
        next_timer = 32'h0;
        if (stalled) next_state = restart ? fan_loop_pkg::ST_LEVEL : fan_loop_pkg::ST_KICK;
        else if (tick && !in_window) next_drive = loop_next;
      end
    endcase
    if (!SPEED_LOOP_ON && state != fan_loop_pkg::ST_DIRECT) begin
      next_state = fan_loop_pkg::ST_DIRECT;
      next_timer = 32'h0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state <= fan_loop_pkg::ST_DIRECT;
      spin_timer <= 32'h0;
      DRIVE_SETTING <= 8'h00;
      SPINUP_FAIL_IRQ <= 1'b0;
    end else begin
      state <= next_state;
      spin_timer <= next_timer;
      DRIVE_SETTING <= next_drive;
      SPINUP_FAIL_IRQ <= spin_fail && SPEED_LOOP_ON;
    end
  end

  assign SPIN_ACTIVE = (state == fan_loop_pkg::ST_KICK) || (state == fan_loop_pkg::ST_LEVEL);

  // Error history advances every update even inside the deadband
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      err1 <= 24'sd0;
      err2 <= 24'sd0;
    end else if (state != fan_loop_pkg::ST_RUN) begin
      err1 <= 24'sd0;
      err2 <= 24'sd0;
    end else if (tick) begin
      err1 <= err0;
      err2 <= err1;
    end
  end

  // Drive-fail: full drive yet slower than target less the band
  assign fail_cond = (state == fan_loop_pkg::ST_RUN) && (DRIVE_SETTING == fan_loop_pkg::DRIVE_FULL)
                     && ({1'b0, TACH_READING} > {1'b0, TACH_TARGET} + {1'b0, FAIL_BAND});
  assign fail_limit = (spinup_setup.underdrive_window_sel == 2'b00) ? 7'h00 :
                      7'(fan_loop_pkg::FAIL_BASE_PERIODS << (spinup_setup.underdrive_window_sel - 2'b01));

  // Status holds until the loop drops out of closed-loop running
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      fail_count <= 7'h00;
      DRIVE_FAIL <= 1'b0;
    end else if (!fail_cond || fail_limit == 7'h00) begin
      fail_count <= 7'h00;
      if (state != fan_loop_pkg::ST_RUN) DRIVE_FAIL <= 1'b0;
    end else if (tick) begin
      if (fail_count + 7'h01 >= fail_limit) DRIVE_FAIL <= 1'b1;
      else fail_count <= fail_count + 7'h01;
    end
  end

endmodule

/* tb/fan_model.sv */
// Behavioural four-wire fan: rotation pulses and a tach count seen by the block
`timescale 1ns/10ps
module fan_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Commands from the bench
  input wire logic stall,
  input wire logic glitch,
  input wire logic [12:0] run_count,
  // Fan side
  output logic pulse,
  output logic [12:0] reading
);
  logic [3:0] div;
  logic phase;

  // A stalled rotor stops the pulse train instead of leaving it toggling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 4'h0;
      phase <= 1'b0;
    end else if (stall) begin
      div <= 4'h0;
      phase <= 1'b0;
    end else begin
      div <= div + 4'h1;
      if (div == 4'hf) begin
        phase <= ~phase;
      end
    end
  end

  // A glitch command flips the pin for one cycle; a stall reads as the slowest count
  assign pulse = phase ^ glitch;
  assign reading = stall ? 13'h1fff : run_count;
endmodule

/* tb/fan_loop_tuning_and_spinup_chk.sv */
// Assertion checker for the fan loop tuning and spin-up block
`timescale 1ns/10ps
module fan_loop_tuning_and_spinup_chk #(
  parameter int FAN_INDEX = 1
)(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Register port
  input wire fan_loop_pkg::reg_wr_s REG_WR,
  input wire logic [7:0] REG_RD_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic SW_LOCK,
  // Loop inputs
  input wire logic SPEED_LOOP_ON,
  input wire logic [7:0] FAN_SETTING,
  input wire logic [5:0] MAX_STEP,
  // Outputs under watch
  input wire logic [7:0] DRIVE_SETTING,
  input wire logic SPIN_ACTIVE,
  input wire logic SPINUP_FAIL_IRQ,
  input wire logic DRIVE_FAIL
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  logic [7:0] opt_q, gain_q, spin_q, rd_exp, lvl_code;
  logic [1:0] up;
  logic loop_d1, loop_d2;
  wire logic [7:0] opt_a, gain_a, spin_a;
  wire logic dir_now, ramp_dir;

  // Offsets of this fan's registers
  assign opt_a = (FAN_INDEX == 2) ? fan_loop_pkg::OPT_FAN2_ADDR : fan_loop_pkg::OPT_FAN1_ADDR;
  assign gain_a = (FAN_INDEX == 2) ? fan_loop_pkg::GAIN_FAN2_ADDR : fan_loop_pkg::GAIN_FAN1_ADDR;
  assign spin_a = (FAN_INDEX == 2) ? fan_loop_pkg::SPIN_FAN2_ADDR : fan_loop_pkg::SPIN_FAN1_ADDR;

  // Shadow registers rebuilt from port writes, so reads can be judged without the body
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      opt_q <= fan_loop_pkg::OPT_RESET;
      gain_q <= fan_loop_pkg::GAIN_RESET;
      spin_q <= fan_loop_pkg::SPIN_RESET;
      up <= 2'h0;
      loop_d1 <= 1'b0;
      loop_d2 <= 1'b0;
    end else begin
      up <= (up == 2'h3) ? up : up + 2'h1;
      loop_d1 <= SPEED_LOOP_ON;
      loop_d2 <= loop_d1;
      if (REG_WR.en && REG_WR.addr == opt_a) opt_q <= REG_WR.data & fan_loop_pkg::OPT_MASK;
      if (REG_WR.en && REG_WR.addr == gain_a) gain_q <= REG_WR.data & fan_loop_pkg::GAIN_MASK;
      if (REG_WR.en && REG_WR.addr == spin_a && !SW_LOCK) spin_q <= REG_WR.data;
    end
  end

  // Expected read data, spin level code and direct-mode qualifiers
  assign rd_exp = (REG_RD_ADDR == opt_a) ? opt_q : (REG_RD_ADDR == gain_a) ? gain_q :
                  (REG_RD_ADDR == spin_a) ? spin_q : 8'h00;
  assign lvl_code = 8'((int'(spin_q[4:2]) * 1275 + 7700) / 100);
  assign dir_now = up == 2'h3 && !opt_q[6] && !SPEED_LOOP_ON && !loop_d1;
  assign ramp_dir = up == 2'h3 && opt_q[6] && !SPEED_LOOP_ON && !loop_d1 && !loop_d2;

  sequence s_full;
    (DRIVE_SETTING == fan_loop_pkg::DRIVE_FULL) [*8];
  endsequence
  sequence s_hold;
    (!ramp_dir || $stable(DRIVE_SETTING)) [*8];
  endsequence

  property p_readback;
    up == 2'h3 |-> REG_RDATA == $past(rd_exp);
  endproperty
  property p_direct_now;
    dir_now |=> DRIVE_SETTING == $past(FAN_SETTING);
  endproperty
  property p_ramp_cap;
    ramp_dir |=> (DRIVE_SETTING > $past(DRIVE_SETTING) ? DRIVE_SETTING - $past(DRIVE_SETTING)
                 : $past(DRIVE_SETTING) - DRIVE_SETTING) <= {2'h0, $past(MAX_STEP)};
  endproperty
  property p_ramp_pace;
    ramp_dir && $changed(DRIVE_SETTING) |=> s_hold;
  endproperty
  property p_kick;
    $rose(SPIN_ACTIVE) && !spin_q[5] |=> s_full;
  endproperty
  property p_level;
    $rose(SPIN_ACTIVE) && spin_q[5] |=> ##1 (DRIVE_SETTING == lvl_code) [*6];
  endproperty
  property p_fail_pulse;
    SPINUP_FAIL_IRQ |=> !SPINUP_FAIL_IRQ [*8];
  endproperty
  property p_retry;
    SPINUP_FAIL_IRQ && SPEED_LOOP_ON |-> ##[0:2] SPIN_ACTIVE;
  endproperty
  property p_fail_window;
    $rose(DRIVE_FAIL) |-> $past(spin_q[7:6]) != 2'h0 && $past(DRIVE_SETTING) == fan_loop_pkg::DRIVE_FULL;
  endproperty
  property p_fail_clear;
    !SPEED_LOOP_ON && !loop_d1 && !loop_d2 |-> !DRIVE_FAIL;
  endproperty

  a_readback: assert property (p_readback) else $error("register read data wrong");
  a_direct_now: assert property (p_direct_now) else $error("direct drive not applied");
  a_ramp_cap: assert property (p_ramp_cap) else $error("ramp step above max step");
  a_ramp_pace: assert property (p_ramp_pace) else $error("ramp steps too close");
  a_kick: assert property (p_kick) else $error("kick not at full drive");
  a_level: assert property (p_level) else $error("spin level drive wrong");
  a_fail_pulse: assert property (p_fail_pulse) else $error("spin fail pulse too long");
  a_retry: assert property (p_retry) else $error("no spin retry");
  a_fail_window: assert property (p_fail_window) else $error("drive fail set wrongly");
  a_fail_clear: assert property (p_fail_clear) else $error("drive fail kept with loop off");
endmodule

bind fan_loop_tuning_and_spinup fan_loop_tuning_and_spinup_chk #(.FAN_INDEX(FAN_INDEX)) u_chk (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD_ADDR(REG_RD_ADDR), .REG_RDATA(REG_RDATA),
  .SW_LOCK(SW_LOCK), .SPEED_LOOP_ON(SPEED_LOOP_ON), .FAN_SETTING(FAN_SETTING), .MAX_STEP(MAX_STEP),
  .DRIVE_SETTING(DRIVE_SETTING), .SPIN_ACTIVE(SPIN_ACTIVE), .SPINUP_FAIL_IRQ(SPINUP_FAIL_IRQ),
  .DRIVE_FAIL(DRIVE_FAIL));

/* tb/fan_loop_tuning_and_spinup_bench.sv */
// Self-checking bench for the fan loop tuning and spin-up block
`timescale 1ns/10ps
module fan_loop_tuning_and_spinup_bench;
  localparam int UPD_U = 20;
  localparam int SPIN_U = 40;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  fan_loop_pkg::reg_wr_s reg_wr = '0;
  logic [7:0] rd_addr = 8'h00;
  logic lock = 1'b0;
  logic loop_on = 1'b0;
  logic [2:0] upd = 3'h0;
  logic [7:0] fan_set = 8'h00;
  logic [5:0] max_step = 6'h04;
  logic [12:0] target = 13'h0104;
  logic [12:0] valid = 13'h0800;
  logic [12:0] band = 13'h0000;
  logic stall = 1'b1;
  logic glitch = 1'b0;
  logic [12:0] run_count = 13'h0100;
  logic [12:0] reading;
  logic [7:0] rdata, drive;
  logic pulse, clean, spin_act, irq, dfail;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  fan_loop_tuning_and_spinup #(.FAN_INDEX(1), .UPDATE_UNIT_CYCLES(UPD_U), .SPIN_UNIT_CYCLES(SPIN_U))
    u_fan_loop_tuning_and_spinup (
    .CLK_SYS(clk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_RD_ADDR(rd_addr), .REG_RDATA(rdata), .SW_LOCK(lock),
    .SPEED_LOOP_ON(loop_on), .UPDATE_PERIOD_SEL(upd), .FAN_SETTING(fan_set), .MAX_STEP(max_step),
    .TACH_READING(reading), .TACH_TARGET(target), .VALID_TACH_COUNT(valid), .FAIL_BAND(band),
    .ROTATION_PULSE_IN(pulse), .ROTATION_PULSE_CLEAN(clean), .DRIVE_SETTING(drive), .SPIN_ACTIVE(spin_act),
    .SPINUP_FAIL_IRQ(irq), .DRIVE_FAIL(dfail));

  fan_model u_fan_model (.clk(clk), .rst_b(rst_b), .stall(stall), .glitch(glitch), .run_count(run_count),
    .pulse(pulse), .reading(reading));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write strobe stands exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge clk);
    reg_wr.en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_addr <= a;
    repeat (2) @(negedge clk);
    chk("register read", e, rdata);
  endtask

  task automatic wait_spin(input logic lvl);
    for (int i = 0; i < 400 && spin_act !== lvl; i++) @(negedge clk);
  endtask

  task automatic wait_change(input logic [7:0] old);
    for (int i = 0; i < 100 && drive === old; i++) @(negedge clk);
  endtask

  task automatic t_regs;
    rd(8'h33, 8'h28);
    rd(8'h35, 8'h2a);
    rd(8'h36, 8'h19);
    rd(8'h43, 8'h00);
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h7e);
    wr(8'h35, 8'hff);
    rd(8'h35, 8'h3f);
    @(posedge clk);
    lock <= 1'b1;
    wr(8'h36, 8'hff);
    rd(8'h36, 8'h19);
    @(posedge clk);
    lock <= 1'b0;
    wr(8'h36, 8'hff);
    rd(8'h36, 8'hff);
    wr(8'h33, 8'h28);
    wr(8'h35, 8'h2a);
    $display("test registers done");
  endtask

  task automatic t_direct;
    @(posedge clk);
    fan_set <= 8'h5a;
    repeat (3) @(negedge clk);
    chk("direct drive", 8'h5a, drive);
    wr(8'h33, 8'h68);
    @(posedge clk);
    fan_set <= 8'h00;
    wait_change(8'h5a);
    chk("first ramp step", 8'h56, drive);
    repeat (UPD_U / 2) @(negedge clk);
    chk("step held", 8'h56, drive);
    wait_change(8'h56);
    chk("second ramp step", 8'h52, drive);
    wr(8'h33, 8'h28);
    repeat (3) @(negedge clk);
    chk("ramp off jump", 8'h00, drive);
    $display("test direct drive done");
  endtask

  // One-cycle pin glitch with the filter on, then with it bypassed
  task automatic t_filter;
    logic seen;
    for (int f = 0; f < 2; f++) begin
      if (f == 1) wr(8'h33, 8'h08);
      @(posedge clk);
      glitch <= 1'b1;
      @(posedge clk);
      glitch <= 1'b0;
      seen = 1'b0;
      repeat (8) begin
        @(negedge clk);
        seen = seen | clean;
      end
      chk("glitch passed", 8'(f), 8'(seen));
    end
    wr(8'h33, 8'h28);
    $display("test filter done");
  endtask

  task automatic t_levels;
    for (int k = 0; k < 8; k++) begin
      wr(8'h36, 8'(8'h20 + 4 * k));
      @(posedge clk);
      loop_on <= 1'b1;
      wait_spin(1'b1);
      repeat (8) @(negedge clk);
      chk("spin level", 8'((7700 + 1275 * k) / 100), drive);
      @(posedge clk);
      loop_on <= 1'b0;
      repeat (4) @(negedge clk);
    end
    $display("test spin levels done");
  endtask

  // Stalled fan: kick length, failure time and retry for every spin time
  task automatic t_spin_time;
    int n;
    int kick;
    for (int s = 0; s < 4; s++) begin
      wr(8'h36, 8'(8'h18 + s));
      @(posedge clk);
      loop_on <= 1'b1;
      wait_spin(1'b1);
      n = 0;
      kick = 0;
      while (irq !== 1'b1 && n < 800) begin
        @(negedge clk);
        n++;
        if (drive === 8'hff) kick++;
      end
      chk("kick length", 8'h01, 8'(kick >= (SPIN_U / 4 << s) - 1 && kick <= (SPIN_U / 4 << s) + 1));
      chk("spin time", 8'h01, 8'(n >= (SPIN_U << s) - 2 && n <= (SPIN_U << s) + 2));
      repeat (2) @(negedge clk);
      chk("retry", 8'h01, 8'(spin_act));
      @(posedge clk);
      loop_on <= 1'b0;
      repeat (4) @(negedge clk);
    end
    $display("test spin time done");
  endtask

  task automatic t_run;
    logic [7:0] held;
    int n;
    wr(8'h33, 8'h3a);
    wr(8'h36, 8'h18);
    @(posedge clk);
    stall <= 1'b0;
    loop_on <= 1'b1;
    wait_spin(1'b1);
    wait_spin(1'b0);
    held = drive;
    repeat (3 * UPD_U) @(negedge clk);
    chk("deadband hold", held, drive);
    @(posedge clk);
    target <= 13'h0180;
    repeat (3 * UPD_U) @(negedge clk);
    chk("loop lowers drive", 8'h01, 8'(drive < held));
    wr(8'h36, 8'h58);
    @(posedge clk);
    target <= 13'h0010;
    for (n = 0; n < 2000 && drive !== 8'hff; n++) @(negedge clk);
    for (n = 0; n < 2000 && dfail !== 1'b1; n++) @(negedge clk);
    chk("fail window", 8'h01, 8'(n >= 15 * UPD_U - 2 && n <= 16 * UPD_U + 2));
    @(posedge clk);
    loop_on <= 1'b0;
    stall <= 1'b1;
    repeat (4) @(negedge clk);
    chk("fail cleared", 8'h00, 8'(dfail));
    $display("test closed loop done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_direct();
    t_filter();
    t_levels();
    t_spin_time();
    t_run();
    complete_run();
  end
endmodule
